// [vc1_stream_port.sv]
// VC1 512-bit TLP stream port: transmit checking and receive delivery.
// Assumes user logic and link side share the clock; APB for registers.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module vc1_stream_port
	import vc1_stream_pkg::*;
#(
	parameter int CREDIT_W = CREDIT_WIDTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire apb_req_t apb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [DATA_W-1:0] tx_data,
	input wire sideband_t tx_sideband,
	input wire logic tx_valid,
	output logic [DATA_W-1:0] link_tx_data,
	output sideband_t link_tx_sideband,
	output logic link_tx_valid,
	output logic [3:0] link_tx_nullify,
	input wire logic [DATA_W-1:0] link_rx_data,
	input wire sideband_t link_rx_sideband,
	input wire logic link_rx_valid,
	output logic link_rx_ready,
	output logic [DATA_W-1:0] rx_data,
	output sideband_t rx_sideband,
	output logic rx_valid,
	input wire logic rx_credit_gnt,
	output logic rx_credit_rtn,
	output logic rx_active_req,
	input wire logic rx_active_ack,
	input wire logic rx_deact_hint
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] ctrl;
		logic [2:0] err;
		logic [31:0] null_count;
		logic tx_open;
		logic tx_bad;
		logic [DATA_W-1:0] ltx_data;
		sideband_t ltx_sb;
		logic ltx_valid;
		logic [3:0] ltx_null;
		link_state_t state;
		logic [CREDIT_W-1:0] credit;
		logic active_req;
		logic credit_rtn;
		logic stg_full;
		logic [DATA_W-1:0] stg_data;
		sideband_t stg_sb;
		logic rx_ready;
		logic [DATA_W-1:0] rx_data;
		sideband_t rx_sb;
		logic rx_valid;
	} state_t;

	state_t s;
	state_t n;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic flags_legal(input logic [3:0] f);
		return f == FLAGS_NONE || f == FLAGS_ONE || f == FLAGS_TWO ||
			f == FLAGS_THREE || f == FLAGS_FOUR;
	endfunction

	function automatic logic [2:0] flag_count(input logic [3:0] f);
		return 3'($countones(f));
	endfunction

	function automatic logic [3:0] count_flags(input logic [2:0] c);
		case (c)
			3'h0: return FLAGS_NONE;
			3'h1: return FLAGS_ONE;
			3'h2: return FLAGS_TWO;
			3'h3: return FLAGS_THREE;
			default: return FLAGS_FOUR;
		endcase
	endfunction

	// Flags legal, each flagged pointer at or above its slot, strictly rising
	function automatic logic starts_ok(input sideband_t sb);
		logic [3:0][1:0] p;
		logic ok;
		p = {sb.fourth_start_pointer, sb.third_start_pointer,
			sb.second_start_pointer, sb.first_start_pointer};
		ok = flags_legal(sb.start_flags) && flags_legal(sb.end_flags);
		for (int i = 1; i < 4; i++) begin
			if (sb.start_flags[i] && (p[i] < 2'(i) || p[i] <= p[i-1])) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// ----------------------------------------------------------------
	// Parity
	// ----------------------------------------------------------------
	logic [BYTES-1:0] tx_par;
	logic [BYTES-1:0] stg_par;

	odd_parity_gen #(.BYTES(BYTES)) tx_parity (
		.data(tx_data),
		.parity(tx_par)
	);

	odd_parity_gen #(.BYTES(BYTES)) rx_parity (
		.data(s.stg_data),
		.parity(stg_par)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic wr;
	logic par_bad;
	logic [3:0] nullv;
	logic [2:0] nstart;
	logic [2:0] nend;
	logic send;
	logic take;
	logic grant;
	logic leave;

	always_comb begin
		n = s;
		// APB: decode in setup, answer in the access cycle
		n.pready = apb.psel && !apb.penable;
		n.pslverr = 1'b0;
		if (apb.psel && !apb.penable) begin
			n.prdata = 32'h0000_0000;
			if (apb.paddr == CTRL_ADDR) begin
				n.prdata[1:0] = s.ctrl;
			end else if (apb.paddr == STATUS_ADDR) begin
				n.prdata[STAT_STATE_LSB +: 2] = s.state;
				n.prdata[STAT_CREDIT_LSB +: CREDIT_W] = s.credit;
				n.prdata[STAT_STAGE] = s.stg_full;
				n.prdata[STAT_TX_OPEN] = s.tx_open;
			end else if (apb.paddr == NULL_COUNT_ADDR) begin
				n.prdata = s.null_count;
			end else if (apb.paddr == ERROR_ADDR) begin
				n.prdata[2:0] = s.err;
			end else begin
				n.pslverr = 1'b1;
			end
		end
		wr = apb.psel && apb.penable && s.pready && apb.pwrite;
		if (wr && apb.paddr == CTRL_ADDR) begin
			n.ctrl = apb.pwdata[1:0];
		end
		if (wr && apb.paddr == ERROR_ADDR) begin
			n.err = s.err & ~apb.pwdata[2:0];
		end

		// Transmit: check parity and codes, forward, mark nullified ends
		nstart = flag_count(tx_sideband.start_flags);
		nend = flag_count(tx_sideband.end_flags);
		par_bad = tx_valid && s.ctrl[CTRL_PAR_EN] &&
			tx_par != tx_sideband.data_parity;
		nullv = 4'h0;
		if (tx_valid) begin
			nullv = tx_sideband.end_flags & (tx_sideband.abort |
				{4{par_bad}} | {3'h0, s.tx_bad && s.tx_open});
			n.tx_open = s.tx_open ? nstart == nend : nstart > nend;
			n.tx_bad = n.tx_open && ((s.tx_bad && nend == 3'h0) ||
				par_bad || |tx_sideband.abort);
			if (!starts_ok(tx_sideband)) begin
				n.err[ERR_TX_CODE] = 1'b1;
			end
		end
		if (par_bad) begin
			n.err[ERR_INTERNAL] = 1'b1;
		end
		n.ltx_data = tx_data;
		n.ltx_sb = tx_sideband;
		n.ltx_valid = tx_valid;
		n.ltx_null = nullv;
		n.null_count = s.null_count + 32'($countones(nullv));

		// Receive: credit gated delivery from the staging register
		grant = rx_credit_gnt && s.state == LINK_RUN &&
			s.credit != {CREDIT_W{1'b1}};
		send = s.stg_full && s.state == LINK_RUN &&
			(s.credit != '0 || rx_credit_gnt);
		take = link_rx_valid && s.rx_ready;
		n.credit = s.credit + CREDIT_W'(grant) - CREDIT_W'(send);
		n.rx_valid = send;
		n.rx_sb.abort = 4'h0;
		if (send) begin
			n.rx_data = s.stg_data;
			n.rx_sb = s.stg_sb;
			n.rx_sb.start_flags = count_flags(
				flag_count(s.stg_sb.start_flags));
			n.rx_sb.end_flags = count_flags(
				flag_count(s.stg_sb.end_flags));
			n.rx_sb.data_parity = stg_par;
		end
		n.stg_full = (s.stg_full && !send) || take;
		if (take) begin
			n.stg_data = link_rx_data;
			n.stg_sb = link_rx_sideband;
			if (!starts_ok(link_rx_sideband)) begin
				n.err[ERR_RX_CODE] = 1'b1;
			end
		end

		// Activation handshake
		leave = rx_deact_hint || !s.ctrl[CTRL_LINK_EN];
		n.credit_rtn = 1'b0;
		case (s.state)
			LINK_STOP: begin
				if (!leave) begin
					n.state = LINK_ACTIVATE;
				end
			end
			LINK_ACTIVATE: begin
				if (leave) begin
					n.state = LINK_DEACTIVATE;
				end else if (rx_active_ack) begin
					n.state = LINK_RUN;
				end
			end
			LINK_RUN: begin
				if (leave) begin
					n.state = LINK_DEACTIVATE;
					n.credit_rtn = 1'b1;
					n.credit = '0;
				end
			end
			default: begin
				if (!rx_active_ack) begin
					n.state = LINK_STOP;
				end
			end
		endcase
		n.active_req = n.state == LINK_ACTIVATE ||
			n.state == LINK_RUN;
		n.rx_ready = !n.stg_full ||
			(n.credit != '0 && n.state == LINK_RUN);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.state <= LINK_STOP;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign link_tx_data = s.ltx_data;
	assign link_tx_sideband = s.ltx_sb;
	assign link_tx_valid = s.ltx_valid;
	assign link_tx_nullify = s.ltx_null;
	assign link_rx_ready = s.rx_ready;
	assign rx_data = s.rx_data;
	assign rx_sideband = s.rx_sb;
	assign rx_valid = s.rx_valid;
	assign rx_credit_rtn = s.credit_rtn;
	assign rx_active_req = s.active_req;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	credit_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_valid |-> $past(s.state) == LINK_RUN &&
			($past(s.credit) != '0 || $past(rx_credit_gnt)))
		else $error("receive beat sent without credit");

	start_code_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_valid |-> flags_legal(rx_sideband.start_flags))
		else $error("reserved receive start flags");

	end_code_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_valid |-> flags_legal(rx_sideband.end_flags))
		else $error("reserved receive end flags");

	rx_abort_a: assert property (@(posedge clock) disable iff (!rst_n)
		|rx_sideband.abort |-> rx_valid)
		else $error("receive abort without valid");

	resume_a: assert property (@(posedge clock) disable iff (!rst_n)
		(s.stg_full && s.state == LINK_RUN && s.credit == '0 &&
			rx_credit_gnt) |=> rx_valid)
		else $error("stalled beat not resumed after grant");

	credit_return_a: assert property (@(posedge clock) disable iff (!rst_n)
		(s.state == LINK_RUN && rx_deact_hint) |=>
			rx_credit_rtn && s.credit == '0 && !rx_active_req ##1
			!rx_credit_rtn)
		else $error("credits not returned on deactivation");

	req_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		(s.state == LINK_RUN && !rx_deact_hint &&
			s.ctrl[CTRL_LINK_EN]) |=> rx_active_req)
		else $error("activation request dropped while running");

	tx_nullify_a: assert property (@(posedge clock) disable iff (!rst_n)
		(tx_valid && |(tx_sideband.end_flags & tx_sideband.abort)) |=>
			link_tx_valid && |link_tx_nullify)
		else $error("aborted transmit TLP not nullified");

	parity_err_a: assert property (@(posedge clock) disable iff (!rst_n)
		par_bad |=> s.err[ERR_INTERNAL] &&
			(link_tx_nullify == link_tx_sideband.end_flags))
		else $error("parity error not recorded or not nullified");

endmodule

// [vc1_stream_pkg.sv]
// Shared constants and types of the VC1 512-bit TLP stream port.
// Assumes a single user clock; APB register access with 12-bit addresses.
package vc1_stream_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 512;
	localparam int BYTES = 64;
	localparam int CREDIT_WIDTH = 8;
	localparam int ADDR_W = 12;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [11:0] NULL_COUNT_ADDR = 12'h008;
	localparam logic [11:0] ERROR_ADDR = 12'h00C;
	localparam int CTRL_LINK_EN = 0;
	localparam int CTRL_PAR_EN = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam int ERR_INTERNAL = 0;
	localparam int ERR_TX_CODE = 1;
	localparam int ERR_RX_CODE = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_CREDIT_LSB = 8;
	localparam int STAT_STAGE = 16;
	localparam int STAT_TX_OPEN = 17;

	// ----------------------------------------------------------------
	// Flag encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] FLAGS_NONE = 4'h0;
	localparam logic [3:0] FLAGS_ONE = 4'h1;
	localparam logic [3:0] FLAGS_TWO = 4'h3;
	localparam logic [3:0] FLAGS_THREE = 4'h7;
	localparam logic [3:0] FLAGS_FOUR = 4'hF;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [63:0] data_parity;
		logic [3:0] fourth_end_pointer;
		logic [3:0] third_end_pointer;
		logic [3:0] second_end_pointer;
		logic [3:0] first_end_pointer;
		logic [3:0] abort;
		logic [3:0] end_flags;
		logic [1:0] fourth_start_pointer;
		logic [1:0] third_start_pointer;
		logic [1:0] second_start_pointer;
		logic [1:0] first_start_pointer;
		logic [3:0] start_flags;
	} sideband_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum logic [1:0] {
		LINK_STOP = 2'b00,
		LINK_ACTIVATE = 2'b01,
		LINK_RUN = 2'b10,
		LINK_DEACTIVATE = 2'b11
	} link_state_t;

endpackage

// [odd_parity_gen.sv]
// Odd parity per byte of a wide data word.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module odd_parity_gen #(
	parameter int BYTES = 64
) (
	input wire logic [BYTES*8-1:0] data,
	output logic [BYTES-1:0] parity
);

	// ----------------------------------------------------------------
	// One bit per byte, set so that byte plus bit has odd weight
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < BYTES; i++) begin
			parity[i] = ~(^data[i*8 +: 8]);
		end
	end

endmodule

// [vc1_user_model.sv]
// User-side partner of the VC1 receive port: credits and activation.
// Assumes one clock shared with the port, synchronous active-low reset.
`timescale 1ns/10ps
module vc1_user_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic rx_active_req,
	input wire logic rx_valid,
	input wire logic rx_credit_rtn,
	output logic rx_credit_gnt,
	output logic rx_active_ack
);
	logic [3:0] given;
	logic grant;

	// ------------------------------------------------------------
	// Credits and acknowledge
	// ------------------------------------------------------------
	// Up to four outstanding, refilled as beats arrive
	assign grant = rx_active_ack && !hold && given < 4'h4;
	always_ff @(posedge clock) begin
		rx_active_ack <= rst_n && rx_active_req;
		if (!rst_n || !rx_active_req || rx_credit_rtn) begin
			given <= 4'h0;
			rx_credit_gnt <= 1'b0;
		end else begin
			rx_credit_gnt <= grant;
			given <= given + {3'h0, grant} - {3'h0, rx_valid};
		end
	end
endmodule

// [tb_top.sv]
// Self-checking bench of the VC1 stream port with a user-side partner.
// Assumes the port answers APB with one access cycle.
`timescale 1ns/10ps
module tb_top
	import vc1_stream_pkg::*;
;
	typedef struct packed {
		logic [3:0] sf;
		logic [7:0] ptr;
		logic [3:0] ef;
		logic [3:0] ab;
		logic bad;
		logic [3:0] nul;
	} row_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic tx_valid = 1'b0;
	logic link_rx_valid = 1'b0;
	logic rx_deact_hint = 1'b0;
	logic hold = 1'b0;
	apb_req_t apb = '0;
	logic [DATA_W-1:0] tx_data = '0;
	logic [DATA_W-1:0] link_rx_data = '0;
	logic [DATA_W-1:0] link_tx_data, rx_data, d, pd;
	sideband_t tx_sideband = '0;
	sideband_t link_rx_sideband = '0;
	sideband_t link_tx_sideband, rx_sideband, sb, psb;
	logic [31:0] prdata, rd;
	logic pready, pslverr, link_tx_valid, link_rx_ready, rx_valid, err;
	logic rx_credit_gnt, rx_credit_rtn, rx_active_req, rx_active_ack;
	logic [3:0] link_tx_nullify;
	logic [35:0] link_q[$];
	logic [35:0] exp_q[$];
	logic [35:0] e;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	int k;
	logic [3:0] sfs [8] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'h5, 4'h0, 4'h8, 4'h6};
	row_t rows [7] = '{
		'{4'h1, 8'h00, 4'h1, 4'h0, 1'b0, 4'h0},
		'{4'h3, 8'h04, 4'h3, 4'h2, 1'b0, 4'h2},
		'{4'h7, 8'h24, 4'h7, 4'h0, 1'b1, 4'h7},
		'{4'hF, 8'hE4, 4'hF, 4'h8, 1'b0, 4'h8},
		'{4'h1, 8'h02, 4'h0, 4'h0, 1'b1, 4'h0},
		'{4'h0, 8'h00, 4'h1, 4'h0, 1'b0, 4'h1},
		'{4'h1, 8'h03, 4'h1, 4'h1, 1'b0, 4'h1}
	};

	vc1_stream_port vc1_stream_port_inst (.clock, .rst_n, .apb, .prdata,
		.pready, .pslverr, .tx_data, .tx_sideband, .tx_valid, .link_tx_data,
		.link_tx_sideband, .link_tx_valid, .link_tx_nullify, .link_rx_data,
		.link_rx_sideband, .link_rx_valid, .link_rx_ready, .rx_data,
		.rx_sideband, .rx_valid, .rx_credit_gnt, .rx_credit_rtn,
		.rx_active_req, .rx_active_ack, .rx_deact_hint);
	vc1_user_model vc1_user_model_inst (.clock, .rst_n, .hold,
		.rx_active_req, .rx_valid, .rx_credit_rtn, .rx_credit_gnt,
		.rx_active_ack);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [63:0] oddpar(input logic [DATA_W-1:0] v);
		for (int i = 0; i < BYTES; i++)
			oddpar[i] = ~^v[8*i+:8];
	endfunction

	function automatic sideband_t mk(input row_t r, input logic [511:0] v);
		mk = '0;
		mk.start_flags = r.sf;
		{mk.fourth_start_pointer, mk.third_start_pointer,
			mk.second_start_pointer, mk.first_start_pointer} = r.ptr;
		mk.end_flags = r.ef;
		mk.first_end_pointer = 4'hF;
		mk.abort = r.ab;
		mk.data_parity = oddpar(v) ^ {63'h0, r.bad};
	endfunction

	// Link-side beat: legal rising pointers, abort from the low nibble
	function automatic sideband_t rx_beat(input logic [35:0] q);
		rx_beat = '0;
		rx_beat.start_flags = q[35:32];
		{rx_beat.fourth_start_pointer, rx_beat.third_start_pointer,
			rx_beat.second_start_pointer,
			rx_beat.first_start_pointer} = 8'hE4;
		rx_beat.abort = q[3:0];
		rx_beat.data_parity = ~oddpar({16{q[31:0]}});
	endfunction

	task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge clock);
		apb <= '{1'b1, 1'b0, w, a, v};
		@(posedge clock);
		apb.penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		apb <= '0;
	endtask

	task drain;
		for (int i = 0; i < 200 && link_q.size() + exp_q.size() > 0; i++)
			@(posedge clock);
		check(link_q.size() + exp_q.size(), 0);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, timeout, link side and receive monitor
	// ------------------------------------------------------------
	initial begin
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			final_report();
		end
	end

	always @(posedge clock) begin
		if (link_rx_valid && link_rx_ready)
			exp_q.push_back(link_q.pop_front());
		link_rx_valid <= link_q.size() > 0;
		if (link_q.size() > 0) begin
			link_rx_data <= {16{link_q[0][31:0]}};
			link_rx_sideband <= rx_beat(link_q[0]);
		end else begin
			link_rx_data <= ~link_rx_data;
		end
	end

	always @(posedge clock) begin
		if (rst_n && rx_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(rx_valid, 1'b0);
			end else begin
				e = exp_q.pop_front();
				check(rx_data, {16{e[31:0]}});
				check(rx_sideband.start_flags,
					4'hF >> (4 - $countones(e[35:32])));
				check(rx_sideband.data_parity, oddpar({16{e[31:0]}}));
				check(rx_sideband.abort, e[3:0]);
				check(rx_sideband.end_flags, 0);
				check({rx_sideband.fourth_start_pointer,
					rx_sideband.third_start_pointer,
					rx_sideband.second_start_pointer,
					rx_sideband.first_start_pointer}, 8'hE4);
			end
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20)
			@(posedge clock);
		rst_n <= 1'b1;
		#1;
		check({rx_valid, rx_active_req, link_tx_valid, pready}, 4'h0);
		for (k = 0; k < 5; k++) begin
			apb_xfer(1'b0, 12'(4 * k), 32'h0);
			check(rd, k == 0 ? 32'h2 : 32'h0);
			check(err, k == 4);
		end
		$display("test reset done");
		for (k = 0; k <= 7; k++) begin
			@(posedge clock);
			pd = d;
			psb = sb;
			d = {BYTES{8'h11 * 8'(k + 1)}};
			sb = mk(rows[k % 7], d);
			tx_data <= d;
			tx_sideband <= sb;
			tx_valid <= k < 7;
			#1;
			if (k > 0) begin
				check(link_tx_valid, 1'b1);
				check(link_tx_data, pd);
				check(link_tx_sideband, psb);
				check(link_tx_nullify, rows[k-1].nul);
			end
		end
		apb_xfer(1'b0, NULL_COUNT_ADDR, 32'h0);
		check(rd, 32'h7);
		apb_xfer(1'b0, ERROR_ADDR, 32'h0);
		check(rd, 32'h1);
		@(posedge clock);
		tx_sideband <= mk(row_t'{4'h2, 8'h0, 4'h0, 4'h0, 1'b0, 4'h0}, d);
		tx_valid <= 1'b1;
		@(posedge clock);
		tx_valid <= 1'b0;
		apb_xfer(1'b0, ERROR_ADDR, 32'h0);
		check(rd, 32'h3);
		apb_xfer(1'b1, ERROR_ADDR, 32'h3);
		apb_xfer(1'b0, ERROR_ADDR, 32'h0);
		check(rd, 32'h0);
		for (k = 0; k < 2; k++) begin
			@(posedge clock);
			tx_sideband <= mk(row_t'{4'h3, (k == 0 ? 8'h05 : 8'h00),
				4'h0, 4'h0, 1'b0, 4'h0}, d);
			tx_valid <= 1'b1;
			@(posedge clock);
			tx_valid <= 1'b0;
			apb_xfer(1'b0, ERROR_ADDR, 32'h0);
			check(rd, 32'h2);
			apb_xfer(1'b1, ERROR_ADDR, 32'h2);
		end
		$display("test transmit done");
		apb_xfer(1'b1, CTRL_ADDR, 32'h3);
		for (k = 0; k < 10 && rx_active_req !== 1'b1; k++)
			@(posedge clock);
		check(rx_active_req, 1'b1);
		for (k = 0; k < 8; k++)
			link_q.push_back({sfs[k], 32'hA0000000 + 32'(k)});
		drain();
		hold <= 1'b1;
		repeat (5)
			@(posedge clock);
		for (k = 0; k < 6; k++)
			link_q.push_back({4'h1, 32'hB0000000 + 32'(k)});
		repeat (30)
			@(posedge clock);
		#1;
		check(rx_valid, 1'b0);
		check(link_rx_ready, 1'b0);
		apb_xfer(1'b0, STATUS_ADDR, 32'h0);
		check(rd[STAT_STAGE], 1'b1);
		@(posedge clock);
		hold <= 1'b0;
		for (k = 0; k < 20 && rx_credit_gnt !== 1'b1; k++)
			@(posedge clock);
		#1;
		check(rx_valid, 1'b1);
		drain();
		$display("test receive done");
		@(posedge clock);
		rx_deact_hint <= 1'b1;
		for (k = 0; k < 20 && rx_credit_rtn !== 1'b1; k++)
			@(posedge clock);
		check(rx_credit_rtn, 1'b1);
		check(rx_active_req, 1'b0);
		repeat (5)
			@(posedge clock);
		apb_xfer(1'b0, STATUS_ADDR, 32'h0);
		check(rd[15:0], 16'h0);
		$display("test deactivate done");
		final_report();
	end
endmodule
